// File: dv/serial_flash_protect_map_test.sv
// Self-checking bench for the protection map
`default_nettype none
module serial_flash_protect_map_test import sfpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, wpN = 1, mode3 = 0;
  logic sclkLink, selectN, serialInLine, serialOutLine, serialOutOe, opValid, rejValid;
  sfpm_op_t opKind;
  sfpm_why_t rejWhy;
  logic [21:0] opAddr;
  logic [8:0] opLen;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0, rx;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] dec;
  logic [30:0] opInfo;
  int failCount = 0, nCompared = 0;
  always #4 clk_sys = ~clk_sys;
  sfpm_top i_sfpm_top (.clk_sys, .rstn, .sclkLink, .selectN, .serialInLine, .serialOutLine,
    .serialOutOe, .wpN, .opValid, .opKind, .opAddr, .opLen, .rejValid, .rejWhy, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  sfpm_spi_master i_sfpm_spi_master (.sclkLink, .selectN, .serialInLine, .serialOutLine);
  // Catch decision pulses
  always @(posedge clk_sys)
  begin
    if (opValid || rejValid)
      dec = {1'b1, opValid, opValid ? 3'(opKind) : 3'(rejWhy)};
    if (opValid)
      opInfo = {opLen, opAddr};
  end
  // Output released while deselected
  always @(negedge clk_sys)
    if (selectN && serialOutOe !== 1'b0)
      chk(serialOutOe, 0);
  task automatic giveVerdict();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    rsp = bresp;
    bready <= 1'b0;
    if (!bvalid) chk(1, 0);
    if (!bvalid) giveVerdict();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
    if (!rvalid) chk(1, 0);
    if (!rvalid) giveVerdict();
  endtask
  // One frame, then the decision it must produce
  task automatic run(input logic [63:0] d, input int nb, input logic [4:0] e);
    dec = 5'h0;
    i_sfpm_spi_master.frame(d, nb, mode3, rx);
    repeat (12) @(posedge clk_sys);
    chk(dec, e);
  endtask
  task automatic we();
    run({CMD_WREN, 56'h0}, 8, 5'h0);
  endtask
  task automatic se(input int s, input logic ok);
    we();
    run({CMD_SE, 2'b00, 6'(s), 48'h0}, 32, ok ? {2'b11, OP_SE} : {2'b10, WHY_PROT});
  endtask
  task automatic wrsr(input logic [7:0] v, input logic [4:0] e);
    we();
    run({CMD_WRSR, v, 48'h0}, 16, e);
  endtask
  // Main sequence
  initial
  begin
    int n;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rchk(REG_STATUS, 32'h0000_0100, RESP_OKAY);
    rchk(8'h20, 32'h0, RESP_SLVERR);
    axw(REG_CTRL, 32'h1);
    rchk(REG_CTRL, 32'h1, RESP_OKAY);
    we();
    run({CMD_PROG, 56'h0}, 40, {2'b10, WHY_BUSY});
    axw(REG_CTRL, 32'h0);
    run({CMD_WRDI, 56'h0}, 8, 5'h0);
    axw(8'h20, 32'h1);
    chk(rsp, RESP_SLVERR);
    run({CMD_PROG, 56'h0}, 40, {2'b10, WHY_WEL});
    we();
    run({CMD_PROG, 56'h0}, 41, {2'b10, WHY_BYTES});
    run({CMD_SE, 56'h0}, 40, {2'b10, WHY_LEN});
    run({CMD_PROG, 24'h00_00FF, 32'h0}, 48, {2'b11, OP_PROG});
    chk(opInfo, {9'd1, 22'hFF});
    run({CMD_PROG, 24'h00_00FF, 32'h0}, 48, {2'b10, WHY_WEL});
    rchk(REG_LAST, 32'h2100_00FF, RESP_OKAY);
    rchk(REG_COUNT, 32'h0005_0001, RESP_OKAY);
    we();
    run({CMD_OTPP, 24'h00_003E, 32'h0}, 64, {2'b11, OP_OTPP});
    chk(opInfo, {9'd2, 22'h3E});
    we();
    run({CMD_SSE, 24'h3F_F123, 32'h0}, 32, {2'b11, OP_SSE});
    chk(opInfo, {9'd0, 22'h3F_F000});
    we();
    run({CMD_BE, 56'h0}, 8, {2'b11, OP_BE});
    chk(opInfo, 0);
    // Every region code from the top, then from the bottom in idle-high mode
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 8; c++)
      begin
        mode3 = 1'(b);
        n = (c == 0) ? 0 : (c == 7) ? 64 : 1 << (c - 1);
        wrsr({2'b00, 1'(b), 3'(c), 2'b00}, 5'h0);
        if (n > 0) se(b ? n - 1 : 64 - n, 1'b0);
        if (n < 64) se(b ? n : 63 - n, 1'b1);
      end
    wrsr(8'h00, 5'h0);
    mode3 = 1'b0;
    we();
    run({CMD_WRLR, 24'h05_0000, 8'h01, 24'h0}, 40, 5'h0);
    se(5, 1'b0);
    se(4, 1'b1);
    we();
    run({CMD_WRLR, 24'h05_0000, 8'h03, 24'h0}, 40, 5'h0);
    we();
    run({CMD_WRLR, 24'h05_0000, 8'h00, 24'h0}, 40, {2'b10, WHY_DOWN});
    se(5, 1'b0);
    rchk(REG_LOCKLO, 32'h0000_0020, RESP_OKAY);
    rchk(REG_DOWNLO, 32'h0000_0020, RESP_OKAY);
    wrsr(8'h80, 5'h0);
    wpN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wrsr(8'h84, {2'b10, WHY_GUARD});
    run({CMD_RDSR, 56'h0}, 16, 5'h0);
    chk(rx, 8'h82);
    rchk(REG_STATUS, 32'h0000_0082, RESP_OKAY);
    giveVerdict();
  end
endmodule // serial_flash_protect_map_test
`default_nettype wire

// File: dv/sfpm_spi_master.sv
// Serial link master model for the protection map
`default_nettype none
module sfpm_spi_master (
  output var logic  sclkLink,
  output var logic  selectN,
  output var logic  serialInLine,
  input  wire logic serialOutLine
);
  timeunit 1ns;
  timeprecision 1ns;
  // Link idle: deselected, clock still
  initial
  begin
    sclkLink = 1'b0;
    selectN = 1'b1;
    serialInLine = 1'b1;
  end
  // One frame MSB first, 160 ns per bit, clock idles at idleHi
  task automatic frame(input logic [63:0] d, input int nb, input bit idleHi,
                       output logic [7:0] rx);
    sclkLink = idleHi;
    #37 selectN = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      #40 sclkLink = 1'b0;
      serialInLine = d[63-i];
      #80 sclkLink = 1'b1;
      rx = {rx[6:0], serialOutLine};
      #40;
    end
    sclkLink = idleHi;
    #40 selectN = 1'b1;
    serialInLine = ~serialInLine; // Released line shows no stale bit
  endtask
endmodule // sfpm_spi_master
`default_nettype wire

// File: inc/sfpm_pkg.sv
// Constants and types for the serial flash protection map block
`default_nettype none
package sfpm_pkg;
  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W     = 22;
  localparam int SECTOR_LSB = 16;
  localparam int SUBSEC_LSB = 12;
  localparam int PAGE_LSB   = 8;
  localparam int PAGE_BYTES = 256;
  localparam int OTP_BYTES  = 64;
  localparam int SECTORS    = 64;

  // ****************************************************************
  // Command codes and status byte layout
  // ****************************************************************
  localparam logic [7:0] CMD_WREN  = 8'h06;
  localparam logic [7:0] CMD_WRDI  = 8'h04;
  localparam logic [7:0] CMD_RDSR  = 8'h05;
  localparam logic [7:0] CMD_WRSR  = 8'h01;
  localparam logic [7:0] CMD_WRLR  = 8'hE5;
  localparam logic [7:0] CMD_PROG  = 8'h02;
  localparam logic [7:0] CMD_OTPP  = 8'h42;
  localparam logic [7:0] CMD_SSE   = 8'h20;
  localparam logic [7:0] CMD_SE    = 8'hD8;
  localparam logic [7:0] CMD_BE    = 8'hC7;
  localparam int ST_GUARD = 7;
  localparam int ST_BOT   = 5;
  localparam int ST_BP_LO = 2;
  localparam int ST_WEL   = 1;
  localparam int ST_BUSY  = 0;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CTRL    = 8'h04;
  localparam logic [7:0] REG_LAST    = 8'h08;
  localparam logic [7:0] REG_COUNT   = 8'h0C;
  localparam logic [7:0] REG_LOCKLO  = 8'h10;
  localparam logic [7:0] REG_LOCKHI  = 8'h14;
  localparam logic [7:0] REG_DOWNLO  = 8'h18;
  localparam logic [7:0] REG_DOWNHI  = 8'h1C;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] BP_RESET    = 3'h0;

  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_OTPP, OP_SSE, OP_SE, OP_BE} sfpm_op_t;
  typedef enum logic [2:0] {WHY_OK, WHY_BYTES, WHY_WEL, WHY_BUSY, WHY_PROT, WHY_DOWN,
                            WHY_GUARD, WHY_LEN} sfpm_why_t;
endpackage
`default_nettype wire

// File: rtl/sfpm_region_dec.sv
// Region code decoder: is a sector inside the protected area
`default_nettype none
module sfpm_region_dec
  import sfpm_pkg::*;
(
  input  wire logic [2:0] code,
  input  wire logic       fromBottom,
  input  wire logic [5:0] sector,
  output logic            hit
);
  logic [6:0] span;

  // Protected sector count: none, 1,2,4,8,16,32, then all
  always_comb
  begin
    unique case (code)
      3'h0:    span = 7'h00;
      3'h7:    span = 7'(SECTORS);
      default: span = 7'(1) << (code - 3'h1);
    endcase
    if (fromBottom)
      hit = {1'b0, sector} < span;
    else
      hit = {1'b0, sector} >= (7'(SECTORS) - span);
  end
endmodule // sfpm_region_dec
`default_nettype wire

// File: rtl/sfpm_sync.sv
// Two-flop level synchroniser, one per bit
`default_nettype none
module sfpm_sync #(
  parameter int        W     = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sfpm_sync_t;
  sfpm_sync_t s_q;
  sfpm_sync_t s_d;

  // ****************************************************************
  // Next state: first stage feeds only the second
  // ****************************************************************
  always_comb
  begin
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  // Register stage
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '{meta: INIT, stable: INIT};
    else
      s_q <= s_d;
  end

  assign q = s_q.stable;
endmodule // sfpm_sync
`default_nettype wire

// File: rtl/sfpm_top.sv
// Serial flash protection map: link capture, write-protect checks, AXI4-Lite view
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module sfpm_top
  import sfpm_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                sclkLink,
  input  wire logic                selectN,
  input  wire logic                serialInLine,
  output logic                     serialOutLine,
  output logic                     serialOutOe,
  input  wire logic                wpN,
  output logic                     opValid,
  output sfpm_pkg::sfpm_op_t       opKind,
  output logic [sfpm_pkg::ADDR_W-1:0] opAddr,
  output logic [8:0]               opLen,
  output logic                     rejValid,
  output sfpm_pkg::sfpm_why_t      rejWhy,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [7:0]          awaddr,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [7:0]          araddr,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp
);
  import sfpm_pkg::*;

  // ****************************************************************
  // Link domain: shift in on rising clock edges
  // ****************************************************************
  typedef struct packed {
    logic [15:0] cnt;
    logic [6:0]  sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  dat;
  } sfpm_link_t;
  sfpm_link_t lk_q;
  sfpm_link_t lk_d;
  logic       arm_q;
  logic       armRstN;
  logic [7:0] statLink;
  logic [7:0] byteIn;
  logic [15:0] cntNext;

  // Arm flag set while deselected, so next frame restarts the count
  assign armRstN = rstn & ~selectN;
  always_ff @(posedge sclkLink or negedge armRstN)
  begin
    if (!armRstN)
      arm_q <= 1'b1;
    else
      arm_q <= 1'b0;
  end

  // Count bits and file the first five completed bytes; idle level does not matter
  always_comb
  begin
    lk_d    = lk_q;
    cntNext = arm_q ? 16'h0001 : lk_q.cnt + 16'h0001;
    byteIn  = {(arm_q ? 7'h00 : lk_q.sh), serialInLine};
    lk_d.cnt = cntNext;
    lk_d.sh  = byteIn[6:0];
    if (cntNext[2:0] == 3'h0)
    begin
      unique case (cntNext[15:3])
        13'h1:   lk_d.op          = byteIn;
        13'h2:   lk_d.addr[23:16] = byteIn;
        13'h3:   lk_d.addr[15:8]  = byteIn;
        13'h4:   lk_d.addr[7:0]   = byteIn;
        13'h5:   lk_d.dat         = byteIn;
        default: lk_d.dat         = lk_q.dat;
      endcase
    end
  end

  always_ff @(posedge sclkLink or negedge rstn)
  begin
    if (!rstn)
      lk_q <= '0;
    else
      lk_q <= lk_d;
  end

  // ****************************************************************
  // Link domain: status readback launched on falling edges
  // ****************************************************************
  typedef struct packed {
    logic dout;
    logic oe;
  } sfpm_out_t;
  sfpm_out_t ou_q;
  sfpm_out_t ou_d;

  // Status byte MSB first, repeating, after the read opcode
  always_comb
  begin
    ou_d.oe   = 1'b1;
    ou_d.dout = 1'b1;
    if (lk_q.op == CMD_RDSR && lk_q.cnt >= 16'h0008)
      ou_d.dout = statLink[3'h7 - lk_q.cnt[2:0]];
  end

  // Driver released asynchronously on deselect
  always_ff @(negedge sclkLink or negedge armRstN)
  begin
    if (!armRstN)
      ou_q <= '{dout: 1'b1, oe: 1'b0};
    else
      ou_q <= ou_d;
  end

  assign serialOutLine = ou_q.dout;
  assign serialOutOe   = ou_q.oe;

  // ****************************************************************
  // Crossings
  // ****************************************************************
  logic       csSync;
  logic       wpSync;
  logic [7:0] statSys;

  sfpm_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk  (clk_sys),
    .rstn (rstn),
    .d    (selectN),
    .q    (csSync)
  );
  sfpm_sync #(.W(1), .INIT(1'b1)) u_wp_sync (
    .clk  (clk_sys),
    .rstn (rstn),
    .d    (wpN),
    .q    (wpSync)
  );
  sfpm_sync #(.W(8), .INIT(8'h00)) u_stat_sync (
    .clk  (sclkLink),
    .rstn (rstn),
    .d    (statSys),
    .q    (statLink)
  );

  // ****************************************************************
  // System domain state
  // ****************************************************************
  typedef struct packed {
    logic              csPrev;
    logic              wel;
    logic              guard;
    logic              bottom;
    logic [2:0]        bp;
    logic [SECTORS-1:0] lock;
    logic [SECTORS-1:0] down;
    logic              hold;
    logic              opValid;
    sfpm_op_t          opKind;
    logic [ADDR_W-1:0] opAddr;
    logic [8:0]        opLen;
    logic              rejValid;
    sfpm_why_t         rejWhy;
    logic              lastOk;
    logic [15:0]       nGrant;
    logic [15:0]       nReject;
    logic              awGot;
    logic              wGot;
    logic [7:0]        awAddr;
    logic [31:0]       wData;
    logic              wLane0;
    logic              awReady;
    logic              wReady;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arReady;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
  } sfpm_sys_t;
  sfpm_sys_t s_q;
  sfpm_sys_t s_d;

  logic              frameEnd;
  logic              wholeBytes;
  logic [12:0]       nBytes;
  logic [5:0]        sector;
  logic              regionHit;
  logic              sectorBlocked;
  logic              modifying;
  sfpm_op_t          kind;
  sfpm_why_t         why;
  logic [12:0]       progBytes;

  assign statSys = {s_q.guard, 1'b0, s_q.bottom, s_q.bp, s_q.wel, s_q.hold};
  assign frameEnd   = csSync & ~s_q.csPrev;
  assign wholeBytes = (lk_q.cnt[2:0] == 3'h0) && (lk_q.cnt != 16'h0000);
  assign nBytes     = lk_q.cnt[15:3];
  assign sector     = lk_q.addr[ADDR_W-1:SECTOR_LSB];
  assign progBytes  = nBytes - 13'h4;

  sfpm_region_dec u_region (
    .code       (s_q.bp),
    .fromBottom (s_q.bottom),
    .sector     (sector),
    .hit        (regionHit)
  );
  assign sectorBlocked = regionHit | s_q.lock[sector];

  // ****************************************************************
  // Command classification and refusal reason
  // ****************************************************************
  always_comb
  begin
    kind      = OP_NONE;
    modifying = 1'b1;
    why       = WHY_OK;
    unique case (lk_q.op)
      CMD_PROG: kind = OP_PROG;
      CMD_OTPP: kind = OP_OTPP;
      CMD_SSE:  kind = OP_SSE;
      CMD_SE:   kind = OP_SE;
      CMD_BE:   kind = OP_BE;
      CMD_WRSR, CMD_WRLR: kind = OP_NONE;
      default:  modifying = 1'b0;
    endcase
    if (!wholeBytes)
      why = WHY_BYTES;
    else if (!s_q.wel)
      why = WHY_WEL;
    else if (s_q.hold)
      why = WHY_BUSY;
    else
    begin
      unique case (lk_q.op)
        CMD_WRSR: if (nBytes != 13'h2) why = WHY_LEN;
                  else if (s_q.guard && !wpSync) why = WHY_GUARD;
        CMD_WRLR: if (nBytes != 13'h5) why = WHY_LEN;
                  else if (s_q.down[sector]) why = WHY_DOWN;
        CMD_PROG: if (nBytes < 13'h5) why = WHY_LEN;
                  else if (sectorBlocked) why = WHY_PROT;
        CMD_OTPP: if (nBytes < 13'h5 || lk_q.addr[23:6] != '0) why = WHY_LEN;
        CMD_SSE, CMD_SE: if (nBytes != 13'h4) why = WHY_LEN;
                  else if (sectorBlocked) why = WHY_PROT;
        CMD_BE:   if (nBytes != 13'h1) why = WHY_LEN;
                  else if (s_q.bp != 3'h0 || s_q.lock != '0) why = WHY_PROT;
        default:  why = WHY_OK;
      endcase
    end
  end

  // ****************************************************************
  // System next state: frame decisions and AXI4-Lite slave
  // ****************************************************************
  always_comb
  begin
    s_d          = s_q;
    s_d.csPrev   = csSync;
    s_d.opValid  = 1'b0;
    s_d.rejValid = 1'b0;
    // Frame decision once the link state is frozen by deselect
    if (frameEnd)
    begin
      if (lk_q.op == CMD_WREN && wholeBytes)
        s_d.wel = 1'b1;
      else if (lk_q.op == CMD_WRDI && wholeBytes)
        s_d.wel = 1'b0;
      else if (modifying && why != WHY_OK)
      begin
        s_d.rejValid = 1'b1;
        s_d.rejWhy   = why;
        s_d.lastOk   = 1'b0;
        s_d.nReject  = s_q.nReject + 16'h0001;
      end
      else if (modifying)
      begin
        s_d.wel    = 1'b0;
        s_d.lastOk = 1'b1;
        s_d.nGrant = s_q.nGrant + 16'h0001;
        if (lk_q.op == CMD_WRSR)
        begin
          s_d.guard  = lk_q.addr[16+ST_GUARD];
          s_d.bottom = lk_q.addr[16+ST_BOT];
          s_d.bp     = lk_q.addr[16+ST_BP_LO +: 3];
        end
        else if (lk_q.op == CMD_WRLR)
        begin
          s_d.lock[sector] = lk_q.dat[0];
          s_d.down[sector] = lk_q.dat[1];
        end
        else
        begin
          s_d.opValid = 1'b1;
          s_d.opKind  = kind;
          s_d.opAddr  = lk_q.addr[ADDR_W-1:0];
          s_d.opLen   = 9'h000;
          if (kind == OP_SSE)
            s_d.opAddr[SUBSEC_LSB-1:0] = '0;
          if (kind == OP_SE)
            s_d.opAddr[SECTOR_LSB-1:0] = '0;
          if (kind == OP_BE)
            s_d.opAddr = '0;
          if (kind == OP_PROG || kind == OP_OTPP)
            s_d.opLen = (progBytes > 13'(PAGE_BYTES) - 13'(lk_q.addr[7:0]))
                        ? 9'(PAGE_BYTES) - 9'(lk_q.addr[7:0])
                        : progBytes[8:0];
          if (kind == OP_OTPP && progBytes > 13'(OTP_BYTES) - 13'(lk_q.addr[5:0]))
            s_d.opLen = 9'(OTP_BYTES) - 9'(lk_q.addr[5:0]);
        end
      end
    end
    // Write address and data taken in either order
    if (awvalid && s_q.awReady)
    begin
      s_d.awGot  = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && s_q.wReady)
    begin
      s_d.wGot   = 1'b1;
      s_d.wData  = wdata;
      s_d.wLane0 = wstrb[0];
    end
    if (s_q.awGot && s_q.wGot && !s_q.bValid)
    begin
      s_d.awGot  = 1'b0;
      s_d.wGot   = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp  = RESP_OKAY;
      if (s_q.awAddr[7:2] == REG_CTRL[7:2])
      begin
        if (s_q.wLane0)
          s_d.hold = s_q.wData[0];
      end
      else if (s_q.awAddr[7:2] > REG_DOWNHI[7:2])
        s_d.bResp = RESP_SLVERR;
    end
    if (s_q.bValid && bready)
      s_d.bValid = 1'b0;
    s_d.awReady = !s_d.awGot && !s_d.bValid;
    s_d.wReady  = !s_d.wGot && !s_d.bValid;
    // Read channel
    if (arvalid && s_q.arReady)
    begin
      s_d.rValid = 1'b1;
      s_d.rResp  = RESP_OKAY;
      unique case (araddr[7:2])
        REG_STATUS[7:2]: s_d.rData = {23'h0, wpSync, statSys};
        REG_CTRL[7:2]:   s_d.rData = {31'h0, s_q.hold};
        REG_LAST[7:2]:   s_d.rData = {s_q.lastOk, s_q.rejWhy, 1'b0, s_q.opKind,
                                      2'h0, s_q.opAddr};
        REG_COUNT[7:2]:  s_d.rData = {s_q.nReject, s_q.nGrant};
        REG_LOCKLO[7:2]: s_d.rData = s_q.lock[31:0];
        REG_LOCKHI[7:2]: s_d.rData = s_q.lock[63:32];
        REG_DOWNLO[7:2]: s_d.rData = s_q.down[31:0];
        REG_DOWNHI[7:2]: s_d.rData = s_q.down[63:32];
        default:
        begin
          s_d.rData = 32'h0000_0000;
          s_d.rResp = RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.rValid && rready)
      s_d.rValid = 1'b0;
    s_d.arReady = !s_d.rValid;
  end

  // Registers; lock-down clears only here, at reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q        <= '0;
      s_q.csPrev <= 1'b1;
      s_q.bp     <= BP_RESET;
      s_q.opKind <= OP_NONE;
      s_q.rejWhy <= WHY_OK;
    end
    else
      s_q <= s_d;
  end

  assign opValid  = s_q.opValid;
  assign opKind   = s_q.opKind;
  assign opAddr   = s_q.opAddr;
  assign opLen    = s_q.opLen;
  assign rejValid = s_q.rejValid;
  assign rejWhy   = s_q.rejWhy;
  assign awready  = s_q.awReady;
  assign wready   = s_q.wReady;
  assign bvalid   = s_q.bValid;
  assign bresp    = s_q.bResp;
  assign arready  = s_q.arReady;
  assign rvalid   = s_q.rValid;
  assign rdata    = s_q.rData;
  assign rresp    = s_q.rResp;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_wel_needed: assert property (s_q.opValid |-> $past(s_q.wel) && !s_q.wel)
    else $error("operation granted without write enable latch");
  a_whole_bytes: assert property (s_q.opValid |-> $past(wholeBytes))
    else $error("operation granted on partial byte");
  a_sector_lock: assert property (s_q.opValid
    && s_q.opKind inside {OP_PROG, OP_SSE, OP_SE}
    |-> !s_q.lock[s_q.opAddr[ADDR_W-1:SECTOR_LSB]])
    else $error("operation granted on locked sector");
  a_bulk_clear: assert property (s_q.opValid && s_q.opKind == OP_BE
    |-> s_q.bp == 3'h0 && s_q.lock == '0)
    else $error("bulk erase granted with protection set");
  a_down_frozen: assert property (
    ((s_q.lock ^ $past(s_q.lock)) & $past(s_q.down)) == '0
    && (s_q.down & $past(s_q.down)) == $past(s_q.down))
    else $error("locked-down sector protection changed");
  a_guard_hold: assert property (s_q.guard && !wpSync
    |=> {s_q.guard, s_q.bottom, s_q.bp} == $past({s_q.guard, s_q.bottom, s_q.bp}))
    else $error("region code changed while guarded");
  a_page_bound: assert property (s_q.opValid && s_q.opKind == OP_PROG
    |-> 10'(s_q.opAddr[7:0]) + 10'(s_q.opLen) <= 10'(PAGE_BYTES))
    else $error("program crosses page");
  a_erase_align: assert property (s_q.opValid && s_q.opKind == OP_SSE
    |-> s_q.opAddr[SUBSEC_LSB-1:0] == '0)
    else $error("subsector erase not aligned");
  a_out_release: assert property (csSync |-> !ou_q.oe)
    else $error("serial output driven while deselected");
  a_reject_pulse: assert property (s_q.rejValid |=> !s_q.rejValid ##1 !s_q.opValid)
    else $error("reject pulse longer than one cycle");

  c_program: cover property (s_q.opValid && s_q.opKind == OP_PROG);
  c_erase:   cover property (s_q.opValid && s_q.opKind == OP_SE);
  c_reject:  cover property (s_q.rejValid && s_q.rejWhy == WHY_PROT);
  c_lockdn:  cover property (s_q.down != '0);
endmodule // sfpm_top
`default_nettype wire
